/* File: nbls_steer.sv */
// Contract
// - even byte on D15-D8, lane1 strobes
// - odd byte on D7-D0, lane0 strobes
// - even word single cycle, both lanes
// - longword two cycles, high half first
// - quadword four cycles, bits 63-48 first
// - quadword middle halves descending significance
`include "nbls_map.svh"
`timescale 1ns/1ns
`default_nettype none
module nbls_steer #(
    parameter int FIFO_DEPTH = `NBLS_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    // request side
    input  wire logic                req_valid,
    output logic                     req_ready,
    input  wire nbls_pkg::nbls_req_s req,
    // bus cycle side
    output logic                     cyc_valid,
    input  wire logic                cyc_ready,
    output nbls_pkg::nbls_cyc_s      cyc
);
    initial begin
        if (FIFO_DEPTH < 2) $error("fifo depth too small");
    end
    // ****************************************
    // request buffer
    // ****************************************
    nbls_pkg::nbls_req_s head;
    logic                head_valid;
    logic                head_pop;
    nbls_fifo #(
        .WIDTH ($bits(nbls_pkg::nbls_req_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (req),
        .out_valid (head_valid),
        .out_ready (head_pop),
        .out_data  (head)
    );
    // ****************************************
    // splitter
    // ****************************************
    nbls_pkg::nbls_state_e state;
    nbls_pkg::nbls_state_e next_state;
    logic [2:0]            beat;
    logic [2:0]            next_beat;
    logic [2:0]            beats;
    nbls_pkg::nbls_cyc_s   next_cyc;
    logic                  next_cyc_valid;
    logic                  out_free;
    logic [15:0]           half;
    // one bus cycle built from head and beat index
    always_comb begin
        out_free       = !cyc_valid || cyc_ready;
        next_state     = state;
        next_beat      = beat;
        next_cyc       = cyc;
        next_cyc_valid = cyc_valid && !cyc_ready;
        head_pop       = 1'b0;
        unique case (head.size)
            `NBLS_SIZE_LONG: beats = `NBLS_BEATS_LONG;
            `NBLS_SIZE_QUAD: beats = `NBLS_BEATS_QUAD;
            default:         beats = 3'h1;
        endcase
        // most significant halfword first
        unique case (head.size)
            `NBLS_SIZE_QUAD: half = head.wdata[6'(63 - 16 * beat) -: 16];
            `NBLS_SIZE_LONG: half = head.wdata[6'(31 - 16 * beat) -: 16];
            default:         half = head.wdata[15:0];
        endcase
        if (out_free && head_valid) begin
            next_cyc_valid     = 1'b1;
            next_cyc           = '0;
            next_cyc.write     = head.write;
            next_cyc.addr      = head.addr + 32'(beat) * `NBLS_ADDR_STEP;
            next_cyc.last      = (beat == beats - 3'h1);
            if (head.size == `NBLS_SIZE_BYTE) begin
                if (head.addr[0]) begin
                    next_cyc.data[7:0]     = head.wdata[7:0];
                    next_cyc.column_strobe = 4'h1;
                end else begin
                    next_cyc.data[15:8]    = head.wdata[7:0];
                    next_cyc.column_strobe = 4'h2;
                end
            end else begin
                next_cyc.data[15:0]    = half;
                next_cyc.column_strobe = 4'h3;
            end
            next_cyc.data_mask    = next_cyc.column_strobe;
            next_cyc.write_strobe = head.write ? next_cyc.column_strobe : 4'h0;
            if (next_cyc.last) begin
                next_beat  = 3'h0;
                head_pop   = 1'b1;
                next_state = nbls_pkg::NBLS_IDLE;
            end else begin
                next_beat  = beat + 3'h1;
                next_state = nbls_pkg::NBLS_BUSY;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state     <= nbls_pkg::NBLS_IDLE;
            beat      <= 3'h0;
            cyc       <= '0;
            cyc_valid <= 1'b0;
        end else if (clk_en) begin
            state     <= next_state;
            beat      <= next_beat;
            cyc       <= next_cyc;
            cyc_valid <= next_cyc_valid;
        end
    end
endmodule
`default_nettype wire

/* File: nbls_map.svh */
`ifndef NBLS_MAP_SVH
`define NBLS_MAP_SVH
// access size codes
`define NBLS_SIZE_BYTE  2'h0
`define NBLS_SIZE_WORD  2'h1
`define NBLS_SIZE_LONG  2'h2
`define NBLS_SIZE_QUAD  2'h3
// bus cycles per access size
`define NBLS_BEATS_LONG 3'h2
`define NBLS_BEATS_QUAD 3'h4
// halfword address step
`define NBLS_ADDR_STEP  32'h0000_0002
// default fifo depth
`define NBLS_FIFO_DEPTH 32
`endif

/* File: nbls_pkg.sv */
package nbls_pkg;
    // one request from the core side
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  size;
        logic        write;
        logic [63:0] wdata;
    } nbls_req_s;
    // one bus cycle on the narrow device
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  write_strobe;
        logic [3:0]  column_strobe;
        logic [3:0]  data_mask;
        logic        write;
        logic        last;
    } nbls_cyc_s;
    typedef enum logic [1:0] {
        NBLS_IDLE = 2'b01,
        NBLS_BUSY = 2'b10
    } nbls_state_e;
endpackage

/* File: nbls_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module nbls_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;
    // pointers and flags
    always_comb begin
        in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid   = wr_ptr != rd_ptr;
        out_data    = mem[rd_ptr[AW-1:0]];
        push        = clk_en && in_valid && in_ready;
        pop         = clk_en && out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
    // storage, no reset
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

/* File: nbls_steer_props.sv */
`timescale 1ns/1ns
`default_nettype none
module nbls_steer_props (
    // watched ports
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                clk_en,
    input wire logic                cyc_valid,
    input wire logic                cyc_ready,
    input wire nbls_pkg::nbls_cyc_s cyc
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // one accepted beat that is not the last of its access
    sequence s_mid; cyc_valid && cyc_ready && clk_en && !cyc.last; endsequence
    property p_even; cyc_valid && cyc.column_strobe == 4'h2 |-> !cyc.addr[0] && cyc.last; endproperty
    a_even: assert property (p_even) else $error("even byte lane");
    property p_odd; cyc_valid && cyc.addr[0] |-> cyc.column_strobe == 4'h1 && cyc.last; endproperty
    a_odd: assert property (p_odd) else $error("odd byte lane");
    property p_word; cyc_valid && cyc.column_strobe == 4'h3 |-> !cyc.addr[0]; endproperty
    a_word: assert property (p_word) else $error("word alignment");
    property p_next; s_mid |=> cyc_valid && cyc.addr == $past(cyc.addr) + 32'h2; endproperty
    a_next: assert property (p_next) else $error("next beat address");
    property p_both; s_mid |-> cyc.column_strobe == 4'h3 && cyc.data_mask == 4'h3; endproperty
    a_both: assert property (p_both) else $error("burst strobes");
    property p_ord; s_mid |-> cyc.addr[2:1] != 2'h3; endproperty
    a_ord: assert property (p_ord) else $error("burst order");
    property p_up; cyc_valid |-> cyc.data[31:16] == 16'h0 && cyc.column_strobe[3:2] == 2'h0
        && cyc.write_strobe[3:2] == 2'h0 && cyc.data_mask[3:2] == 2'h0; endproperty
    a_up: assert property (p_up) else $error("upper lanes used");
endmodule
bind nbls_steer nbls_steer_props u_nbls_steer_props (.clk_sys, .rst_n, .clk_en, .cyc_valid,
    .cyc_ready, .cyc);
`default_nettype wire

/* File: nbls_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module nbls_dev_model (
    // bus side of the narrow device
    input wire logic                clk_sys,
    input wire logic                clk_en,
    input wire logic                stall,
    input wire logic                cyc_valid,
    input wire nbls_pkg::nbls_cyc_s cyc,
    output logic                    cyc_ready
);
    nbls_pkg::nbls_cyc_s seen[$];
    // wait states on demand, every taken beat logged
    assign cyc_ready = !stall;
    always @(posedge clk_sys) begin
        if (cyc_valid && cyc_ready && clk_en) seen.push_back(cyc);
    end
endmodule
`default_nettype wire

/* File: test_narrow_bus_byte_lane_steering.sv */
`timescale 1ns/1ns
`default_nettype none
module test_narrow_bus_byte_lane_steering;
    logic clk_sys, rst_n, clk_en, req_valid, req_ready, cyc_valid, cyc_ready, stall, hold;
    nbls_pkg::nbls_req_s req;
    nbls_pkg::nbls_cyc_s cyc, g, e, exp_q[$];
    int errors, compares, seed;
    nbls_steer #(.FIFO_DEPTH(4)) u_nbls_steer (.clk_sys, .rst_n, .clk_en, .req_valid,
        .req_ready, .req, .cyc_valid, .cyc_ready, .cyc);
    nbls_dev_model u_nbls_dev_model (.clk_sys, .clk_en, .stall, .cyc_valid, .cyc, .cyc_ready);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // random clock enable and far-side wait states
    always @(posedge clk_sys) begin
        clk_en <= ($random(seed) % 8) != 0;
        stall <= hold || ($random(seed) % 4 == 0);
    end
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic nbls_pkg::nbls_req_s mk(logic [1:0] s, logic [31:0] a, logic w,
        logic [63:0] d);
        mk = '{addr: a & ~((32'h1 << s) - 32'h1), size: s, write: w, wdata: d};
    endfunction
    // expected beats: high halves first, halfword steps
    task automatic expect_req(input nbls_pkg::nbls_req_s r);
        int n;
        nbls_pkg::nbls_cyc_s c;
        n = r.size == 2'h3 ? 4 : r.size == 2'h2 ? 2 : 1;
        for (int i = 0; i < n; i++) begin
            c = '0;
            c.addr = r.addr + 32'(2 * i);
            c.data[15:0] = r.wdata[16 * (n - 1 - i) +: 16];
            c.column_strobe = r.size != 2'h0 ? 4'h3 : r.addr[0] ? 4'h1 : 4'h2;
            if (r.size == 2'h0) c.data[15:0] = {r.wdata[7:0], r.wdata[7:0]};
            if (!r.write) c.data = '0;
            c.data_mask = c.column_strobe;
            c.write_strobe = r.write ? c.column_strobe : 4'h0;
            c.write = r.write;
            c.last = i == n - 1;
            exp_q.push_back(c);
        end
    endtask
    task automatic send(input nbls_pkg::nbls_req_s r);
        req <= r;
        req_valid <= 1'b1;
        do @(negedge clk_sys); while (!(req_ready && clk_en));
        @(posedge clk_sys);
        expect_req(r);
    endtask
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        end_sim();
    end
    initial begin
        seed = 32'h42417dae;
        {rst_n, req_valid, hold, clk_en, stall} = 5'h00;
        req = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        hold <= 1'b1;
        // every size, both byte parities, far side held until refusal
        fork
            for (int s = 0; s < 10; s++) send(mk(2'(s), 32'h1000 + 8 * s + (s == 4), s < 8,
                64'h0123_4567_89ab_cdef));
            begin
                repeat (40) @(negedge clk_sys);
                check(req_ready, 1'b0);
                @(posedge clk_sys);
                hold <= 1'b0;
            end
        join
        $display("fill test done");
        repeat (200) send(mk(2'($random(seed)), $random(seed), 1'($random(seed)),
            {$random(seed), $random(seed)}));
        req_valid <= 1'b0;
        while (u_nbls_dev_model.seen.size() < exp_q.size()) @(posedge clk_sys);
        repeat (20) @(posedge clk_sys);
        check(u_nbls_dev_model.seen.size(), exp_q.size());
        // unused byte lane and read data are not compared
        foreach (exp_q[i]) begin
            g = u_nbls_dev_model.seen[i];
            e = exp_q[i];
            if (!e.write) g.data = '0;
            if (e.column_strobe == 4'h2) g.data[7:0] = e.data[7:0];
            if (e.column_strobe == 4'h1) g.data[15:8] = e.data[15:8];
            check(g, e);
        end
        $display("random test done");
        end_sim();
    end
endmodule
`default_nettype wire
